// ===== hw/ppmh_pkg.sv
package ppmh_pkg;

  // Function power state encodings
  localparam logic [1:0] PPMH_PS_D0    = 2'h0;
  localparam logic [1:0] PPMH_PS_D1    = 2'h1;
  localparam logic [1:0] PPMH_PS_D2    = 2'h2;
  localparam logic [1:0] PPMH_PS_D3HOT = 2'h3;

  // Advertised fast-training-sequence count
  localparam logic [7:0] PPMH_NFTS_DEFAULT = 8'hFF;

  // Register indices (word addresses)
  localparam logic [3:0] PPMH_REG_CTRL   = 4'h0;
  localparam logic [3:0] PPMH_REG_STATUS = 4'h1;
  localparam logic [3:0] PPMH_REG_NFTS   = 4'h2;

  // CTRL fields
  localparam int PPMH_CTRL_ASPM_L0S = 0;
  localparam int PPMH_CTRL_ASPM_L1  = 1;

  // Idle cycles before ASPM entry, from a time in ns rounded up to whole clocks
  localparam int PPMH_ASPM_IDLE_NS  = 70;
  localparam int PPMH_CLK_NS        = 10;
  localparam int PPMH_ASPM_IDLE_CYC = (PPMH_ASPM_IDLE_NS + PPMH_CLK_NS - 1) / PPMH_CLK_NS;

  // Link power states reported to software
  typedef enum logic [2:0] {
    PPMH_LNK_DOWN,
    PPMH_LNK_L0,
    PPMH_LNK_L0S,
    PPMH_LNK_L1,
    PPMH_LNK_L23_RDY,
    PPMH_LNK_OFF
  } ppmh_link_t;

endpackage : ppmh_pkg

// ===== hw/ppmh_sync.sv
`timescale 1ns/100ps
module ppmh_sync (
  input  wire logic clk_i,    // Core clock
  input  wire logic rst_n_i,  // Async reset
  input  wire logic d_i,      // Async level
  output logic      q_o       // Filtered level
);
  logic s1_q, s2_q, s3_q, q_q;
  logic q_d;

  // Change counts only when stages two and three agree
  always_comb begin
    q_d = (s2_q == s3_q) ? s3_q : q_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q_q  <= 1'b0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q  <= q_d;
    end
  end

  assign q_o = q_q;
endmodule : ppmh_sync

// ===== hw/ppmh_aspm.sv
`timescale 1ns/100ps
module ppmh_aspm
  import ppmh_pkg::*;
(
  input  wire logic clk_i,      // Core clock
  input  wire logic rst_n_i,    // Async reset
  input  wire logic link_up_i,  // Link in L0
  input  wire logic idle_i,     // No traffic either way
  input  wire logic l0s_en_i,   // L0s permitted
  input  wire logic l1_en_i,    // L1 permitted
  output logic      in_l0s_o,   // Autonomous L0s
  output logic      in_l1_o     // Autonomous L1
);
  logic [7:0] cnt_q, cnt_d;
  logic       l0s_q, l0s_d, l1_q, l1_d;

  always_comb begin
    cnt_d = cnt_q;
    l0s_d = l0s_q;
    l1_d  = l1_q;
    if (!link_up_i || !idle_i) begin
      cnt_d = 8'h00;
      l0s_d = 1'b0;
      l1_d  = 1'b0;
    end else if (cnt_q < 8'(PPMH_ASPM_IDLE_CYC)) begin
      cnt_d = cnt_q + 8'h01;
    end else begin
      l1_d  = l1_en_i;
      l0s_d = l0s_en_i && !l1_en_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 8'h00;
      l0s_q <= 1'b0;
      l1_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      l0s_q <= l0s_d;
      l1_q  <= l1_d;
    end
  end

  assign in_l0s_o = l0s_q;
  assign in_l1_o  = l1_q;
endmodule : ppmh_aspm

// ===== hw/ppmh_top.sv
`timescale 1ns/100ps
module ppmh_top
  import ppmh_pkg::*;
#(
  parameter bit GEN3_CAPABLE = 1'b0,  // Built for third-generation speed
  parameter bit ASYNC_CLKING = 1'b0   // Non-synchronous clocking mode
) (
  input  wire logic       clk_i,             // Core user clock
  input  wire logic       rst_n_i,           // Async reset, active low
  input  wire logic [3:0] reg_addr_i,        // Register index
  input  wire logic [7:0] reg_wdata_i,       // Write data
  input  wire logic       reg_wr_i,          // Write strobe
  input  wire logic       reg_rd_i,          // Read strobe
  output logic      [7:0] reg_rdata_o,       // Read data, cycle after strobe
  input  wire logic       train_done_i,      // Link training completed
  input  wire logic       link_idle_i,       // No traffic on the link
  input  wire logic [1:0] pm_state_wr_i,     // Power state written upstream
  input  wire logic       pm_state_wr_vld_i, // Power state write pulse
  input  wire logic       turnoff_msg_i,     // PME_Turn_Off received pulse
  input  wire logic       pm_dllp_ack_i,     // Partner acknowledged L1 request
  input  wire logic       user_ack_i,        // Power-change acknowledge
  input  wire logic       rq_valid_i,        // User request beat valid
  input  wire logic       rq_last_i,         // User request last beat
  output logic            req_stream_ready_o,// Request stream ready
  output logic      [1:0] func_pwr_state_o,  // Function power state
  output logic            turnoff_notice_o,  // Power-change request
  output logic            pm_dllp_req_l1_o,  // Send L1 entry DLLP
  output logic            pme_to_ack_o,      // Send PME_TO_Ack pulse
  output logic            layers_en_o,       // Phy, link and transaction on
  output logic      [7:0] nfts_o,            // Advertised FTS count
  output logic      [2:0] link_state_o       // Link power state
);

  typedef enum logic [2:0] {
    PPMH_ST_DOWN,
    PPMH_ST_L0,
    PPMH_ST_L1_REQ,
    PPMH_ST_L1,
    PPMH_ST_TO_WAIT,
    PPMH_ST_TO_ACK,
    PPMH_ST_OFF
  } ppmh_st_t;

  ppmh_st_t   st_q, st_d;
  logic [1:0] pwr_q, pwr_d;
  logic       mid_q, mid_d;
  logic       ntc_q, ntc_d;
  logic       ack_q, ack_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [7:0] nfts_q, nfts_d;
  logic [7:0] rdata_q, rdata_d;
  logic       ack_s;
  logic       in_l0s, in_l1;
  logic       aspm_ok, l0s_ok;

  function automatic logic is_d0(input logic [1:0] s);
    return s == PPMH_PS_D0;
  endfunction : is_d0

  // Acknowledge comes from unrelated user logic timing, filter it
  ppmh_sync u_ack_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (user_ack_i),
    .q_o     (ack_s)
  );

  assign aspm_ok = !ASYNC_CLKING && (st_q == PPMH_ST_L0);
  assign l0s_ok  = !GEN3_CAPABLE && ctrl_q[PPMH_CTRL_ASPM_L0S];

  // Autonomous, nothing from user side
  ppmh_aspm u_aspm (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .link_up_i (aspm_ok),
    .idle_i    (link_idle_i),
    .l0s_en_i  (l0s_ok),
    .l1_en_i   (ctrl_q[PPMH_CTRL_ASPM_L1]),
    .in_l0s_o  (in_l0s),
    .in_l1_o   (in_l1)
  );

  // Main sequencer
  always_comb begin
    st_d  = st_q;
    pwr_d = pwr_q;
    ntc_d = ntc_q;
    ack_d = 1'b0;
    if (pm_state_wr_vld_i && st_q != PPMH_ST_OFF) begin
      pwr_d = pm_state_wr_i;
    end
    case (st_q)
      PPMH_ST_DOWN: begin
        if (train_done_i) begin
          st_d = PPMH_ST_L0;
        end
      end
      PPMH_ST_L0: begin
        if (!train_done_i) begin
          st_d = PPMH_ST_DOWN;
        end else if (!is_d0(pwr_d)) begin
          st_d = PPMH_ST_L1_REQ;
        end
      end
      PPMH_ST_L1_REQ: begin
        if (is_d0(pwr_q)) begin
          st_d = PPMH_ST_L0;
        end else if (pm_dllp_ack_i) begin
          st_d = PPMH_ST_L1;
        end
      end
      PPMH_ST_L1: begin
        if (is_d0(pwr_q)) begin
          st_d = PPMH_ST_L0;
        end
      end
      PPMH_ST_TO_WAIT: begin
        if (ack_s) begin
          ntc_d = 1'b0;
          ack_d = 1'b1;
          st_d  = PPMH_ST_TO_ACK;
        end
      end
      PPMH_ST_TO_ACK: begin
        st_d = PPMH_ST_OFF;
      end
      PPMH_ST_OFF: begin
        st_d = PPMH_ST_OFF;
      end
      default: begin
        st_d = PPMH_ST_DOWN;
      end
    endcase
    if (turnoff_msg_i && st_q != PPMH_ST_TO_WAIT && st_q != PPMH_ST_TO_ACK
        && st_q != PPMH_ST_OFF) begin
      st_d  = PPMH_ST_TO_WAIT;
      ntc_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q  <= PPMH_ST_DOWN;
      pwr_q <= PPMH_PS_D0;
      ntc_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      pwr_q <= pwr_d;
      ntc_q <= ntc_d;
      ack_q <= ack_d;
    end
  end

  // Track a request packet in progress so it can finish after stall
  always_comb begin
    mid_d = mid_q;
    if (rq_valid_i && req_stream_ready_o) begin
      mid_d = !rq_last_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mid_q <= 1'b0;
    end else begin
      mid_q <= mid_d;
    end
  end

  // Ready held for the rest of a started packet only
  assign req_stream_ready_o = (st_q != PPMH_ST_OFF) &&
                              (mid_q || (is_d0(pwr_q) && (st_q == PPMH_ST_L0)));

  // Register file
  always_comb begin
    ctrl_d  = ctrl_q;
    nfts_d  = nfts_q;
    rdata_d = 8'h00;
    if (reg_wr_i) begin
      case (reg_addr_i)
        PPMH_REG_CTRL: ctrl_d = reg_wdata_i[1:0];
        PPMH_REG_NFTS: nfts_d = reg_wdata_i;
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        PPMH_REG_CTRL:   rdata_d = {6'h00, ctrl_q};
        PPMH_REG_STATUS: rdata_d = {3'h0, link_state_o, pwr_q};
        PPMH_REG_NFTS:   rdata_d = nfts_q;
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q  <= 2'h0;
      nfts_q  <= PPMH_NFTS_DEFAULT;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q  <= ctrl_d;
      nfts_q  <= nfts_d;
      rdata_q <= rdata_d;
    end
  end

  always_comb begin
    case (st_q)
      PPMH_ST_DOWN:    link_state_o = PPMH_LNK_DOWN;
      PPMH_ST_L0:      link_state_o = in_l1 ? PPMH_LNK_L1 : (in_l0s ? PPMH_LNK_L0S : PPMH_LNK_L0);
      PPMH_ST_L1_REQ:  link_state_o = PPMH_LNK_L0;
      PPMH_ST_L1:      link_state_o = PPMH_LNK_L1;
      PPMH_ST_OFF:     link_state_o = PPMH_LNK_OFF;
      default:         link_state_o = PPMH_LNK_L23_RDY;
    endcase
  end

  assign reg_rdata_o      = rdata_q;
  assign func_pwr_state_o = pwr_q;
  assign turnoff_notice_o = ntc_q;
  assign pme_to_ack_o     = ack_q;
  assign pm_dllp_req_l1_o = (st_q == PPMH_ST_L1_REQ);
  assign layers_en_o      = (st_q != PPMH_ST_OFF);
  assign nfts_o           = nfts_q;

  // Assertions
  AST_NOTICE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ntc_q && !ack_s |=> ntc_q)
    else $error("Power-change request dropped before acknowledge");
  AST_NOTICE_RAISE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    turnoff_msg_i && (st_q == PPMH_ST_L0) |=> ntc_q)
    else $error("Power-change request not raised");
  AST_NOTICE_DROP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ntc_q && ack_s |=> !ntc_q && pme_to_ack_o)
    else $error("Request not dropped after acknowledge");
  AST_TOACK_ONCE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pme_to_ack_o |=> !pme_to_ack_o ##1 !layers_en_o)
    else $error("PME_TO_Ack not single or layers still on");
  AST_STALL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !is_d0(pwr_q) && !mid_q |-> !req_stream_ready_o)
    else $error("Ready while not D0");
  AST_FINISH_PKT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mid_q && layers_en_o |-> req_stream_ready_o)
    else $error("Packet in progress not accepted");
  AST_L0_ENTRY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q == PPMH_ST_DOWN) && train_done_i && !turnoff_msg_i |=> st_q == PPMH_ST_L0)
    else $error("L0 not entered after training");
  AST_NO_L0S_G3: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    GEN3_CAPABLE |-> !in_l0s)
    else $error("L0s in gen3 build");
  AST_NO_ASPM_ASYNC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ASYNC_CLKING |-> !in_l0s && !in_l1)
    else $error("ASPM in non-synchronous mode");
  AST_NFTS_RST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(train_done_i) && !$past(reg_wr_i) |-> nfts_o == $past(nfts_o))
    else $error("FTS count changed without write");
  AST_STATE_OUT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pm_state_wr_vld_i && layers_en_o |=> func_pwr_state_o == $past(pm_state_wr_i))
    else $error("Power state not presented");
  AST_L1_REQ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pm_dllp_req_l1_o && pm_dllp_ack_i && !turnoff_msg_i && !is_d0(pwr_q)
    |=> st_q == PPMH_ST_L1)
    else $error("L1 not reached after DLLP ack");
  // State flop follows the enable one cycle late
  AST_ASPM_AUTO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    in_l1 |-> $past(ctrl_q[PPMH_CTRL_ASPM_L1]))
    else $error("ASPM L1 without enable");
  AST_L23: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ntc_q |-> link_state_o == PPMH_LNK_L23_RDY)
    else $error("Link not L23 Ready during handshake");

  // Only reset brings the interfaces back
  AST_OFF_STICKY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !layers_en_o |=> !layers_en_o && !req_stream_ready_o)
    else $error("Interfaces reopened after turn-off");
  AST_TOACK_CAUSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pme_to_ack_o |-> $past(ack_s))
    else $error("PME_TO_Ack without acknowledge");
  // Low-power entry depends on idle time and the CTRL enable bits
  AST_ASPM_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    in_l0s || in_l1 |-> $past(link_idle_i))
    else $error("ASPM state entered while link busy");

endmodule : ppmh_top

// ===== tb/ppmh_user_model.sv
`timescale 1ns/100ps
module ppmh_user_model #(
  parameter int ACK_DELAY = 6  // One less than the cycles spent draining before acknowledging
) (
  input  wire logic clk_i,            // Core user clock
  input  wire logic rst_n_i,          // Async reset, active low
  input  wire logic turnoff_notice_i, // Power-change request from the block
  output logic      user_ack_o        // Power-change acknowledge
);
  int unsigned wait_cnt;

  // Ack after a fixed count of notice cycles; never withdrawn once given
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_cnt   <= 0;
      user_ack_o <= 1'b0;
    end else if (turnoff_notice_i && !user_ack_o) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt == ACK_DELAY) begin
        user_ack_o <= 1'b1;
      end
    end
  end
endmodule : ppmh_user_model

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import ppmh_pkg::*;

  logic       clk_i;
  logic       rst_n_i;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic       reg_wr_i;
  logic       reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic       train_done_i;
  logic       link_idle_i;
  logic [1:0] pm_state_wr_i;
  logic       pm_state_wr_vld_i;
  logic       turnoff_msg_i;
  logic       pm_dllp_ack_i;
  logic       user_ack_i;
  logic       rq_valid_i;
  logic       rq_last_i;
  logic       req_stream_ready_o;
  logic [1:0] func_pwr_state_o;
  logic       turnoff_notice_o;
  logic       pm_dllp_req_l1_o;
  logic       pme_to_ack_o;
  logic       layers_en_o;
  logic [7:0] nfts_o;
  logic [2:0] link_state_o;
  int         mismatches;
  int         check_count;
  int         cyc;
  int         k;

  ppmh_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .train_done_i(train_done_i), .link_idle_i(link_idle_i),
    .pm_state_wr_i(pm_state_wr_i), .pm_state_wr_vld_i(pm_state_wr_vld_i),
    .turnoff_msg_i(turnoff_msg_i), .pm_dllp_ack_i(pm_dllp_ack_i), .user_ack_i(user_ack_i),
    .rq_valid_i(rq_valid_i), .rq_last_i(rq_last_i), .req_stream_ready_o(req_stream_ready_o),
    .func_pwr_state_o(func_pwr_state_o), .turnoff_notice_o(turnoff_notice_o),
    .pm_dllp_req_l1_o(pm_dllp_req_l1_o), .pme_to_ack_o(pme_to_ack_o),
    .layers_en_o(layers_en_o), .nfts_o(nfts_o), .link_state_o(link_state_o));

  ppmh_user_model user (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .turnoff_notice_i(turnoff_notice_o), .user_ack_o(user_ack_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cycles

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    chk(reg_rdata_o, exp, "read data");
  endtask : reg_check

  // Power write lands while a packet is open; ready must hold until its last beat
  task automatic pwr_write_mid_packet(input logic [1:0] s);
    @(posedge clk_i);
    rq_valid_i        <= 1'b1;
    rq_last_i         <= 1'b0;
    @(posedge clk_i);
    pm_state_wr_i     <= s;
    pm_state_wr_vld_i <= 1'b1;
    @(posedge clk_i);
    pm_state_wr_vld_i <= 1'b0;
    #1;
    chk(8'(func_pwr_state_o), 8'(s), "power state");
    chk(8'(req_stream_ready_o), 8'h01, "ready mid packet");
    @(posedge clk_i);
    rq_last_i  <= 1'b1;
    @(posedge clk_i);
    rq_valid_i <= 1'b0;
    rq_last_i  <= 1'b0;
    #1;
    chk(8'(req_stream_ready_o), 8'h00, "ready after packet");
  endtask : pwr_write_mid_packet

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      $display("Error at %0t: run did not finish in time", $time);
      print_verdict();
    end
  end

  initial begin
    mismatches = 0;
    check_count = 0;
    cyc = 0;
    rst_n_i = 1'b0;
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, train_done_i, link_idle_i} = '0;
    {pm_state_wr_i, pm_state_wr_vld_i, turnoff_msg_i, pm_dllp_ack_i} = '0;
    {rq_valid_i, rq_last_i} = '0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cycles(1);
    chk(nfts_o, PPMH_NFTS_DEFAULT, "fts count");
    chk(8'(layers_en_o), 8'h01, "layers enabled");
    chk(8'(link_state_o), 8'(PPMH_LNK_DOWN), "link down");
    reg_check(PPMH_REG_NFTS, PPMH_NFTS_DEFAULT);
    reg_check(4'hF, 8'h00);
    reg_write(4'hF, 8'hFF);
    reg_check(PPMH_REG_CTRL, 8'h00);
    // A changed sequence count reaches the link side
    reg_write(PPMH_REG_NFTS, 8'h80);
    cycles(1);
    chk(nfts_o, 8'h80, "fts count written");
    reg_check(PPMH_REG_NFTS, 8'h80);
    // Training done with no user action brings the link to L0
    @(posedge clk_i);
    train_done_i <= 1'b1;
    cycles(3);
    chk(8'(link_state_o), 8'(PPMH_LNK_L0), "link active");
    chk(8'(req_stream_ready_o), 8'h01, "ready in L0");
    // Autonomous entry needs idle time and a CTRL enable bit, never a user signal
    for (k = 1; k <= 2; k++) begin
      reg_write(PPMH_REG_CTRL, 8'(k));
      link_idle_i <= 1'b1;
      cycles(PPMH_ASPM_IDLE_CYC + 4);
      chk(8'(link_state_o), (k == 1) ? 8'(PPMH_LNK_L0S) : 8'(PPMH_LNK_L1), "aspm");
      @(posedge clk_i);
      link_idle_i <= 1'b0;
      reg_write(PPMH_REG_CTRL, 8'h00);
      cycles(6);
      chk(8'(link_state_o), 8'(PPMH_LNK_L0), "aspm exit");
    end
    // Every low-power code stalls requests and leads the link to L1
    for (k = 1; k <= 3; k++) begin
      pwr_write_mid_packet(2'(k));
      cycles(2);
      chk(8'(pm_dllp_req_l1_o), 8'h01, "l1 request");
      chk(8'(req_stream_ready_o), 8'h00, "stalled");
      @(posedge clk_i);
      pm_dllp_ack_i <= 1'b1;
      cycles(3);
      @(posedge clk_i);
      pm_dllp_ack_i <= 1'b0;
      chk(8'(link_state_o), 8'(PPMH_LNK_L1), "link in l1");
      reg_check(PPMH_REG_STATUS, {3'h0, 3'(PPMH_LNK_L1), 2'(k)});
      @(posedge clk_i);
      pm_state_wr_i     <= PPMH_PS_D0;
      pm_state_wr_vld_i <= 1'b1;
      @(posedge clk_i);
      pm_state_wr_vld_i <= 1'b0;
      cycles(4);
      chk(8'(req_stream_ready_o), 8'h01, "ready back in D0");
      chk(8'(link_state_o), 8'(PPMH_LNK_L0), "back to L0");
    end
    // Turn-off handshake
    @(posedge clk_i);
    turnoff_msg_i <= 1'b1;
    @(posedge clk_i);
    turnoff_msg_i <= 1'b0;
    #1;
    chk(8'(turnoff_notice_o), 8'h01, "notice raised");
    chk(8'(link_state_o), 8'(PPMH_LNK_L23_RDY), "l23 ready");
    k = 0;
    while (!user_ack_i && k < 50) begin
      chk(8'(turnoff_notice_o), 8'h01, "notice held");
      chk(8'(pme_to_ack_o), 8'h00, "no early ack");
      cycles(1);
      k++;
    end
    k = 0;
    while (pme_to_ack_o !== 1'b1 && k < 8) begin
      cycles(1);
      k++;
    end
    chk(8'(pme_to_ack_o), 8'h01, "turn-off ack sent");
    chk(8'(turnoff_notice_o), 8'h00, "notice dropped");
    cycles(1);
    chk(8'(pme_to_ack_o), 8'h00, "ack one cycle");
    chk(8'(layers_en_o), 8'h00, "layers off");
    chk(8'(req_stream_ready_o), 8'h00, "interface closed");
    chk(8'(link_state_o), 8'(PPMH_LNK_OFF), "link off");
    print_verdict();
  end
endmodule : tb_top
